// File: logic/aircpc_pkg.sv
package aircpc_pkg;
	// ****************************************
	// register map, byte offsets
	// ****************************************
	localparam logic [15:0] A_ADC_SEL = 16'h0000;
	localparam logic [15:0] A_PWR = 16'h0004;
	localparam logic [15:0] A_SRC_PORT = 16'h0008;
	localparam logic [15:0] A_UCTL1 = 16'h000C;
	localparam logic [15:0] A_SPORT = 16'h0010;
	localparam logic [15:0] A_RAMP_CFG = 16'h0014;
	localparam logic [15:0] A_STATUS = 16'h0018;
	localparam logic [3:0] A_PARAM_HI = 4'h1; // 0x1000..0x1FFC
	localparam logic [7:0] A_TGT_HI = 8'h20; // 0x2000..0x20FC
	localparam logic [7:0] A_CUR_HI = 8'h21; // 0x2100..0x21FC
	localparam int PARAM_WORDS = 1024;
	localparam int RAMP_WORDS = 64;

	// ****************************************
	// field positions
	// ****************************************
	localparam int PW_PLL = 15;
	localparam int PW_ADC_A = 14;
	localparam int PW_ADC_B = 13;
	localparam int PW_SRC = 12;
	localparam int PW_DAC0 = 5; // four pair enables, pair 0 feeds headphones
	localparam int PW_HP_A = 4;
	localparam int PW_HP_B = 3;
	localparam int UC_PLL_SEL = 0;
	localparam int UC_RATIO = 1;
	localparam int UC_SRC_MUX = 3;
	localparam int SRC_SEL_LSB = 5;
	localparam int SP_FMT = 0;
	localparam int SP_WL = 2;
	localparam int RC_CURVE = 4;
	localparam logic [1:0] SRC_DEFAULT_CH = 2'h3;
	localparam logic [9:0] RATIO_BASE = 10'h040; // 64 x fs

	// ****************************************
	// encodings and timing
	// ****************************************
	localparam logic [1:0] FMT_I2S = 2'h0;
	localparam logic [1:0] FMT_LJ = 2'h1;
	localparam logic [1:0] FMT_RJ = 2'h2;
	localparam logic [1:0] FMT_TDM = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int CLK_HZ = 40_000_000;
	localparam int FS_HZ = 48_000;
	localparam int TICK_CYC = CLK_HZ / FS_HZ;
	localparam int GAP_CYC = 4;
	typedef enum logic [1:0] {CK_MCLK = 2'b00, CK_GAP = 2'b01, CK_PLL = 2'b10} aircpc_ck_e;
	typedef enum logic [2:0] {
		RG_NONE = 3'b000, RG_REG = 3'b001, RG_PARAM = 3'b010, RG_TGT = 3'b011, RG_CUR = 3'b100
	} aircpc_rg_e;
endpackage

// File: logic/aircpc_top.sv
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
// Summary of operation
// - core takes four stereo serial inputs, 48 kHz
// - 1024-word parameter memory, bus writable
// - 64 ramp locations slew toward written targets
// - everything readable except ramp target memory
// - I2S, LJ, RJ, TDM at 16/20/24 bits
// - one-hot four-bit ADC input pair select
// - ADC runs only with power bits 14, 13
// - rate converter off until its enable set
// - port register bits 6:5 pick converter input
// - mux enable routes input, masks it from core
// - mux enable clear feeds input three instead
// - converter emits 48 kHz sample timing
// - ratio field set to match input clock
// - PLL off by default, needs bit 15
// - clock select bit resets to master clock pin
// - four output pairs, own enables, reset off
// - headphones need bits 4, 3 and pair 0
module aircpc_top
	import aircpc_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write channels
	input wire logic [15:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read channels
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// serial audio link
	input wire logic bit_clk,
	input wire logic frame_clk,
	input wire logic [3:0] serial_audio_input,
	// processing core feed
	output logic [3:0][23:0] core_left,
	output logic [3:0][23:0] core_right,
	output logic core_valid,
	// rate converter feed
	output logic [23:0] src_left,
	output logic [23:0] src_right,
	output logic src_valid,
	output logic src_out_tick,
	// analog routing and power
	output logic [3:0] adc_mux_sel,
	output logic adc_pwr,
	output logic src_pwr,
	output logic pll_pwr,
	output logic [3:0] dac_pwr,
	output logic hp_pwr,
	// core clock selection
	output logic master_clock_pin_en,
	output logic pll_clk_en,
	output logic core_clk_sel,
	output logic [9:0] pll_ratio
);
	// ****************************************
	// state and helpers
	// ****************************************
	typedef struct packed {
		logic aw_h;
		logic [15:0] aw_a;
		logic w_h;
		logic [31:0] w_d;
		logic [3:0] w_s;
		logic bv;
		logic [1:0] br;
		logic rv;
		logic [1:0] rr;
		logic [31:0] rd;
		logic [3:0] adc_sel;
		logic [15:0] pwr;
		logic [1:0] src_sel;
		logic [3:0] uctl;
		logic [3:0] sport;
		logic [4:0] ramp_cfg;
		aircpc_ck_e ck;
		logic [1:0] gap;
		logic [9:0] tick_cnt;
		logic tick;
		logic bclk_d;
		logic lr_d;
		logic [5:0] cnt;
		logic [1:0] slot;
		logic [3:0][31:0] sh;
		logic [3:0][23:0] hold_l;
		logic [3:0][23:0] cl;
		logic [3:0][23:0] cr;
		logic cv;
		logic [23:0] sl;
		logic [23:0] sr;
		logic sv;
		logic sweep;
		logic [5:0] idx;
		logic [RAMP_WORDS-1:0] tw;
		logic [RAMP_WORDS-1:0] cw;
	} aircpc_st_s;

	function automatic aircpc_rg_e region(input logic [15:0] a);
		if (a[1:0] != 2'h0) return RG_NONE;
		if (a[15:12] == A_PARAM_HI) return RG_PARAM;
		if (a[15:8] == A_TGT_HI) return RG_TGT;
		if (a[15:8] == A_CUR_HI) return RG_CUR;
		if (a <= A_STATUS) return RG_REG;
		return RG_NONE;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
			input logic [3:0] s);
		logic [31:0] v;
		v = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) v[b*8 +: 8] = d[b*8 +: 8];
		end
		return v;
	endfunction

	function automatic logic [5:0] wbits(input logic [1:0] wl);
		return (wl == 2'h2) ? 6'd16 : (wl == 2'h1) ? 6'd20 : 6'd24;
	endfunction

	// left-aligns the word so the sign bit lands on bit 23
	function automatic logic [23:0] ext(input logic [31:0] s, input logic [5:0] c,
			input logic [1:0] f, input logic [1:0] wl);
		logic [31:0] v;
		logic [23:0] m;
		m = 24'hFFFFFF << (6'd24 - wbits(wl));
		if (f == FMT_RJ) v = s << (6'd32 - wbits(wl));
		else v = s << (6'd32 - c);
		return v[31:8] & m;
	endfunction

	// one slew step; never overshoots, so no overflow is possible
	function automatic logic [31:0] ramp_step(input logic [31:0] cur, input logic [31:0] tg,
			input logic [4:0] cfg);
		logic signed [32:0] d;
		logic signed [32:0] inc;
		logic signed [32:0] s;
		d = $signed({tg[31], tg}) - $signed({cur[31], cur});
		inc = 33'sh000000001 <<< cfg[3:0];
		if (cfg[RC_CURVE]) begin
			s = d >>> cfg[3:0];
			if (s == 33'sh0) s = d;
		end else if (d > inc) s = inc;
		else if (d < -inc) s = -inc;
		else s = d;
		return cur + s[31:0];
	endfunction

	function automatic logic [31:0] absd(input logic [31:0] a, input logic [31:0] b);
		logic signed [32:0] d;
		d = $signed({a[31], a}) - $signed({b[31], b});
		return (d < 0) ? 32'(-d) : 32'(d);
	endfunction

	aircpc_st_s r;
	aircpc_st_s n;
	logic [31:0] param_mem [PARAM_WORDS];
	logic [31:0] tgt_mem [RAMP_WORDS];
	logic [31:0] cur_mem [RAMP_WORDS];
	logic param_we;
	logic tgt_we;
	logic cur_we;
	logic [31:0] mem_wd;
	logic eng_we;
	logic [31:0] eng_wd;
	logic [31:0] eng_cur;
	logic [31:0] eng_tgt;
	logic desired;
	logic brise;
	logic done;
	logic is_left;
	logic [1:0] src_ch;
	logic [3:0][31:0] shn;
	logic [3:0][23:0] wd;
	logic [31:0] mg;

	// ****************************************
	// next-state logic
	// ****************************************
	always_comb begin
		n = r;
		param_we = 1'b0;
		tgt_we = 1'b0;
		cur_we = 1'b0;
		mem_wd = '0;
		eng_we = 1'b0;
		eng_cur = cur_mem[r.idx];
		eng_tgt = tgt_mem[r.idx];
		eng_wd = ramp_step(eng_cur, eng_tgt, r.ramp_cfg);
		mg = merge('0, r.w_d, r.w_s);
		n.cv = 1'b0;
		n.sv = 1'b0;
		n.tick = 1'b0;
		desired = r.uctl[UC_PLL_SEL] && r.pwr[PW_PLL];
		// bus write: address and data taken in either order
		if (s_axi_awvalid && !r.aw_h) begin
			n.aw_h = 1'b1;
			n.aw_a = s_axi_awaddr;
		end
		if (s_axi_wvalid && !r.w_h) begin
			n.w_h = 1'b1;
			n.w_d = s_axi_wdata;
			n.w_s = s_axi_wstrb;
		end
		if (r.bv && s_axi_bready) n.bv = 1'b0;
		if (r.aw_h && r.w_h && !r.bv) begin
			n.aw_h = 1'b0;
			n.w_h = 1'b0;
			n.bv = 1'b1;
			n.br = RESP_OKAY;
			unique case (region(r.aw_a))
				RG_PARAM: begin
					param_we = 1'b1;
					mem_wd = merge(param_mem[r.aw_a[11:2]], r.w_d, r.w_s);
				end
				RG_TGT: begin
					tgt_we = 1'b1;
					n.tw[r.aw_a[7:2]] = 1'b1;
					mem_wd = merge(tgt_mem[r.aw_a[7:2]], r.w_d, r.w_s);
				end
				RG_CUR: begin
					cur_we = 1'b1;
					n.cw[r.aw_a[7:2]] = 1'b1;
					mem_wd = merge(cur_mem[r.aw_a[7:2]], r.w_d, r.w_s);
				end
				RG_REG: begin
					mg = merge({r.pwr, 16'h0} >> 16, r.w_d, r.w_s);
					unique case (r.aw_a)
						A_ADC_SEL: n.adc_sel = r.w_s[0] ? r.w_d[3:0] : r.adc_sel;
						A_PWR: n.pwr = mg[15:0];
						A_SRC_PORT: n.src_sel = r.w_s[0] ? r.w_d[SRC_SEL_LSB +: 2] : r.src_sel;
						A_UCTL1: n.uctl = r.w_s[0] ? r.w_d[3:0] : r.uctl;
						A_SPORT: n.sport = r.w_s[0] ? r.w_d[3:0] : r.sport;
						A_RAMP_CFG: n.ramp_cfg = r.w_s[0] ? r.w_d[4:0] : r.ramp_cfg;
						default: n.br = RESP_SLVERR; // status is read only
					endcase
				end
				default: n.br = RESP_SLVERR;
			endcase
		end
		// bus read: one outstanding, answered next cycle
		if (r.rv && s_axi_rready) n.rv = 1'b0;
		if (s_axi_arvalid && !r.rv) begin
			n.rv = 1'b1;
			n.rr = RESP_OKAY;
			n.rd = '0;
			unique case (region(s_axi_araddr))
				RG_PARAM: n.rd = param_mem[s_axi_araddr[11:2]];
				RG_CUR: n.rd = cur_mem[s_axi_araddr[7:2]];
				RG_REG: begin
					unique case (s_axi_araddr)
						A_ADC_SEL: n.rd = {28'h0, r.adc_sel};
						A_PWR: n.rd = {16'h0, r.pwr};
						A_SRC_PORT: n.rd = {25'h0, r.src_sel, 5'h0};
						A_UCTL1: n.rd = {28'h0, r.uctl};
						A_SPORT: n.rd = {28'h0, r.sport};
						A_RAMP_CFG: n.rd = {27'h0, r.ramp_cfg};
						default: n.rd = {29'h0, desired, r.ck};
					endcase
				end
				default: n.rr = RESP_SLVERR;
			endcase
		end
		// core clock: both gates off for the gap before any switch
		unique case (r.ck)
			CK_MCLK: if (desired) begin
				n.ck = CK_GAP;
				n.gap = 2'(GAP_CYC - 1);
			end
			CK_PLL: if (!desired) begin
				n.ck = CK_GAP;
				n.gap = 2'(GAP_CYC - 1);
			end
			CK_GAP: if (r.gap == 2'h0) n.ck = desired ? CK_PLL : CK_MCLK;
				else n.gap = r.gap - 2'h1;
			default: n.ck = CK_MCLK;
		endcase
		// sample-rate tick for the converter and ramp engine
		if (r.tick_cnt == 10'(TICK_CYC - 1)) begin
			n.tick_cnt = '0;
			n.tick = 1'b1;
		end else n.tick_cnt = r.tick_cnt + 10'h001;
		// ramp sweep: one location per cycle after each tick
		if (r.tick) begin
			n.sweep = 1'b1;
			n.idx = '0;
		end
		// locations never loaded hold unknowns, so the engine skips them
		if (r.sweep && !cur_we) begin
			eng_we = r.tw[r.idx] && r.cw[r.idx];
			n.idx = r.idx + 6'h01;
			if (r.idx == 6'(RAMP_WORDS - 1)) n.sweep = 1'b0;
		end else if (r.sweep) n.idx = r.idx;
		// serial receiver, sampled on bit clock rise
		brise = bit_clk && !r.bclk_d;
		n.bclk_d = bit_clk;
		src_ch = r.uctl[UC_SRC_MUX] ? r.src_sel : SRC_DEFAULT_CH;
		done = 1'b0;
		is_left = 1'b0;
		for (int i = 0; i < 4; i++) begin
			shn[i] = {r.sh[i][30:0], serial_audio_input[i]};
			if (r.sport[SP_FMT +: 2] == FMT_TDM) wd[i] = ext(shn[i], 6'd32, FMT_LJ, r.sport[SP_WL +: 2]);
			else wd[i] = ext(r.sh[i], r.cnt, r.sport[SP_FMT +: 2], r.sport[SP_WL +: 2]);
		end
		if (brise) begin
			n.lr_d = frame_clk;
			n.sh = shn;
			n.cnt = (r.cnt == 6'd32) ? r.cnt : r.cnt + 6'h01;
			if (r.sport[SP_FMT +: 2] == FMT_TDM) begin
				// slots 0 and 1 of each frame carry left and right
				if (frame_clk && !r.lr_d) begin
					n.cnt = 6'h01;
					n.slot = 2'h0;
				end else if (r.cnt == 6'd31) begin
					n.cnt = 6'h00;
					done = (r.slot != 2'h2);
					is_left = (r.slot == 2'h0);
					n.slot = (r.slot == 2'h2) ? r.slot : r.slot + 2'h1;
				end
			end else if (frame_clk != r.lr_d) begin
				done = 1'b1;
				is_left = (r.lr_d == (r.sport[SP_FMT +: 2] != FMT_I2S));
				n.cnt = (r.sport[SP_FMT +: 2] == FMT_I2S) ? 6'h00 : 6'h01;
				for (int i = 0; i < 4; i++) begin
					n.sh[i] = (r.sport[SP_FMT +: 2] == FMT_I2S) ? 32'h0 : {31'h0, serial_audio_input[i]};
				end
			end
		end
		if (done && is_left) n.hold_l = wd;
		if (done && !is_left) begin
			n.cv = 1'b1;
			for (int i = 0; i < 4; i++) begin
				// with the mux enabled, the converter's input is hidden from the core
				if (r.uctl[UC_SRC_MUX] && r.src_sel == 2'(i)) begin
					n.cl[i] = '0;
					n.cr[i] = '0;
				end else begin
					n.cl[i] = r.hold_l[i];
					n.cr[i] = wd[i];
				end
			end
			n.sl = r.hold_l[src_ch];
			n.sr = wd[src_ch];
			n.sv = r.pwr[PW_SRC];
		end
	end

	// ****************************************
	// registers and memories
	// ****************************************
	// all-zero reset leaves every block off and the core on the pin clock
	always_ff @(posedge aclk) begin
		if (!aresetn) r <= '0;
		else r <= n;
	end

	// memories carry no reset; software loads them after boot
	always_ff @(posedge aclk) begin
		if (param_we) param_mem[r.aw_a[11:2]] <= mem_wd;
		if (tgt_we) tgt_mem[r.aw_a[7:2]] <= mem_wd;
		// a bus write wins over the engine for that cycle
		if (cur_we) cur_mem[r.aw_a[7:2]] <= mem_wd;
		else if (eng_we) cur_mem[r.idx] <= eng_wd;
	end

	// ****************************************
	// outputs
	// ****************************************
	assign s_axi_awready = !r.aw_h;
	assign s_axi_wready = !r.w_h;
	assign s_axi_bvalid = r.bv;
	assign s_axi_bresp = r.br;
	assign s_axi_arready = !r.rv;
	assign s_axi_rvalid = r.rv;
	assign s_axi_rdata = r.rd;
	assign s_axi_rresp = r.rr;
	assign core_left = r.cl;
	assign core_right = r.cr;
	assign core_valid = r.cv;
	assign src_left = r.sl;
	assign src_right = r.sr;
	assign src_valid = r.sv;
	assign src_out_tick = r.tick && r.pwr[PW_SRC];
	assign adc_mux_sel = $onehot(r.adc_sel) ? r.adc_sel : 4'h0;
	assign adc_pwr = r.pwr[PW_ADC_A] && r.pwr[PW_ADC_B];
	assign src_pwr = r.pwr[PW_SRC];
	assign pll_pwr = r.pwr[PW_PLL];
	assign dac_pwr = r.pwr[PW_DAC0 +: 4];
	assign hp_pwr = r.pwr[PW_HP_A] && r.pwr[PW_HP_B] && r.pwr[PW_DAC0];
	assign master_clock_pin_en = (r.ck == CK_MCLK);
	assign pll_clk_en = (r.ck == CK_PLL);
	assign core_clk_sel = (r.ck == CK_PLL);
	assign pll_ratio = RATIO_BASE << r.uctl[UC_RATIO +: 2];

	// ****************************************
	// assertions
	// ****************************************
	default clocking dcb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_CLK_EXCL: assert property (!(master_clock_pin_en && pll_clk_en))
		else $error("both core clock gates open");
	AST_CLK_GAP: assert property ($fell(master_clock_pin_en) |-> !pll_clk_en [*4])
		else $error("clock gap too short");
	AST_PLL_OFF: assert property (pll_clk_en && !pll_pwr |=> !pll_clk_en)
		else $error("pll clock kept after power off");
	AST_MCLK_DEF: assert property (!r.uctl[UC_PLL_SEL] [*6] |-> !pll_clk_en)
		else $error("pll clock without select");
	AST_ADC_ONEHOT: assert property ($onehot0(adc_mux_sel))
		else $error("more than one adc pair");
	AST_ADC_PWR: assert property (s_axi_bvalid && !$past(s_axi_bvalid) && $past(r.aw_a) == A_PWR
		&& $past(r.w_s[1]) && $past(r.w_d[14:13]) == 2'h3 |-> adc_pwr)
		else $error("adc not powered by write");
	AST_HP: assert property (hp_pwr |-> dac_pwr[0] && r.pwr[PW_HP_B])
		else $error("headphone on without aux pair");
	AST_MASK: assert property (core_valid && $past(r.uctl[UC_SRC_MUX])
		|-> core_left[$past(r.src_sel)] == 24'h0)
		else $error("masked input reached core");
	AST_SRC_DEF: assert property (src_valid && !$past(r.uctl[UC_SRC_MUX])
		|-> src_left == $past(r.hold_l[3]))
		else $error("converter not fed from input three");
	AST_SRC_PWR: assert property (src_valid |-> $past(src_pwr))
		else $error("converter fed while off");
	AST_RATIO: assert property (r.uctl[2:1] == 2'h3 |-> pll_ratio == 10'd512)
		else $error("ratio 512 decode wrong");
	AST_RAMP: assert property (eng_we |-> absd(eng_wd, eng_tgt) <= absd(eng_cur, eng_tgt))
		else $error("ramp moved away from target");
	AST_TGT_RD: assert property (s_axi_arvalid && s_axi_arready && region(s_axi_araddr) == RG_TGT
		|=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR)
		else $error("target memory read not refused");
	AST_TICK: assert property (src_out_tick |=> !src_out_tick [*8])
		else $error("tick too frequent");
	AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");

	COV_PLL: cover property ($rose(pll_clk_en));
	COV_SRC: cover property (src_valid && r.uctl[UC_SRC_MUX]);
	COV_CORE: cover property (core_valid);
	COV_RAMP: cover property (eng_we && eng_wd != eng_cur);
endmodule

// File: tb/aircpc_top_bench.sv
`timescale 1ns/100ps
module aircpc_top_bench;
	import aircpc_pkg::*;
	// ****************************************
	// stimulus and observed signals
	// ****************************************
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [15:0] awaddr = 16'h0000;
	logic [15:0] araddr = 16'h0000;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic bit_clk = 1'b0;
	logic frame_clk = 1'b0;
	logic [3:0] ser_in = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, core_valid, src_valid, src_out_tick;
	logic adc_pwr, src_pwr, pll_pwr, hp_pwr, mclk_en, pll_en, clk_sel;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [3:0][23:0] core_l, core_r, core_lq, core_rq;
	logic [23:0] src_l, src_r, src_lq, src_rq;
	logic [3:0] adc_sel, dac_pwr;
	logic [9:0] ratio;
	logic [23:0] exp_l [4];
	logic [23:0] exp_r [4];
	logic [31:0] lfsr = 32'h0000974C;
	logic got_src = 1'b0;
	int error_cnt = 0;
	int n_checks = 0;
	int cyc_cnt = 0;
	int tick_cnt = 0;
	int tick_gap = 0;
	int tick_last = 0;
	int gap_cnt = 0;

	// 25 ns period
	always #12.5 aclk = ~aclk;

	aircpc_top i_dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.bit_clk(bit_clk), .frame_clk(frame_clk), .serial_audio_input(ser_in),
		.core_left(core_l), .core_right(core_r), .core_valid(core_valid),
		.src_left(src_l), .src_right(src_r), .src_valid(src_valid),
		.src_out_tick(src_out_tick), .adc_mux_sel(adc_sel), .adc_pwr(adc_pwr),
		.src_pwr(src_pwr), .pll_pwr(pll_pwr), .dac_pwr(dac_pwr), .hp_pwr(hp_pwr),
		.master_clock_pin_en(mclk_en), .pll_clk_en(pll_en), .core_clk_sel(clk_sel),
		.pll_ratio(ratio)
	);

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic finish_test();
		if (error_cnt == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	// address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] rsp);
		rsp = 2'h1;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awvalid === 1'b1 && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid === 1'b1 && wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				rsp = bresp;
				break;
			end
		end
		bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic axi_rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] rsp);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid === 1'b1 && arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				d = rdata;
				rsp = rresp;
				break;
			end
		end
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	// left-justified frame, 24 bits a word, bit clock idle low outside it
	// frame pulses high at bit 48 to close the right word, then rests low
	task automatic send_lj();
		int b;
		int j;
		got_src = 1'b0;
		for (b = 0; b < 52; b++) begin
			frame_clk <= (b < 24) || (b == 48);
			for (j = 0; j < 4; j++) begin
				ser_in[j] <= (b < 24) ? exp_l[j][23 - b] : (b < 48) ? exp_r[j][47 - b] : 1'b0;
			end
			repeat (2) @(posedge aclk);
			bit_clk <= 1'b1;
			repeat (2) @(posedge aclk);
			bit_clk <= 1'b0;
		end
		ser_in <= ~ser_in;
		repeat (6) @(posedge aclk);
	endtask

	// ****************************************
	// monitors and hang guard
	// ****************************************
	// one block so that the cycle count and the captures never race
	always @(posedge aclk) begin
		cyc_cnt++;
		if (src_out_tick === 1'b1) begin
			tick_gap = cyc_cnt - tick_last;
			tick_last = cyc_cnt;
			tick_cnt++;
		end
		if (src_valid === 1'b1) begin
			got_src = 1'b1;
			src_lq = src_l;
			src_rq = src_r;
		end
		if (core_valid === 1'b1) begin
			core_lq = core_l;
			core_rq = core_r;
		end
		if (aresetn && mclk_en === 1'b0 && pll_en === 1'b0) gap_cnt++;
		if (mclk_en === 1'b1 && pll_en === 1'b1) chk("clock gates overlap", 0, 1);
		if (cyc_cnt == 60000) begin
			error_cnt++;
			finish_test();
		end
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		int i;
		int k;
		int n;
		int ln;
		logic [31:0] v;
		logic [31:0] d;
		logic [1:0] rsp;
		logic [31:0] pv [3];
		pv = '{32'h0000E038, 32'h00000018, 32'h00006000};
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("powers after reset", 0, 32'({adc_pwr, src_pwr, pll_pwr, hp_pwr, dac_pwr}));
		chk("mclk_en after reset", 1, 32'(mclk_en));
		chk("ratio after reset", 64, 32'(ratio));
		// every four-bit select code, one-hot ones pass through
		for (i = 0; i < 16; i++) begin
			axi_wr(A_ADC_SEL, 32'(i), rsp);
			repeat (2) @(posedge aclk);
			chk("adc_mux_sel", ($countones(i[3:0]) == 1) ? 32'(i) : 0, 32'(adc_sel));
		end
		chk("tick unpowered", 0, 32'(tick_cnt));
		// fixed corner values, then random words
		for (i = 0; i < 12; i++) begin
			lfsr = lfsr_next(lfsr);
			v = (i < 3) ? pv[i] : (lfsr & 32'h0000FFFF);
			axi_wr(A_PWR, v, rsp);
			chk("pwr bresp", 32'(RESP_OKAY), 32'(rsp));
			repeat (2) @(posedge aclk);
			chk("adc_pwr", 32'(v[14] & v[13]), 32'(adc_pwr));
			chk("src_pwr", 32'(v[12]), 32'(src_pwr));
			chk("pll_pwr", 32'(v[15]), 32'(pll_pwr));
			chk("dac_pwr", 32'(v[8:5]), 32'(dac_pwr));
			chk("hp_pwr", 32'(v[4] & v[3] & v[5]), 32'(hp_pwr));
		end
		for (i = 0; i < 4; i++) begin
			axi_wr(A_UCTL1, 32'(i) << UC_RATIO, rsp);
			repeat (2) @(posedge aclk);
			chk("pll_ratio", 32'(64 << i), 32'(ratio));
		end
		// pll selected but unpowered must keep the pin clock
		axi_wr(A_PWR, 32'h00000000, rsp);
		axi_wr(A_UCTL1, 32'h00000001, rsp);
		repeat (20) @(posedge aclk);
		chk("mclk_en unpowered pll", 1, 32'(mclk_en));
		gap_cnt = 0;
		axi_wr(A_PWR, 32'h00008000, rsp);
		for (n = 0; n < 40 && pll_en !== 1'b1; n++) @(posedge aclk);
		chk("pll_en", 1, 32'(pll_en));
		chk("core_clk_sel", 1, 32'(clk_sel));
		chk("clock gap", 32'(GAP_CYC), 32'(gap_cnt));
		axi_wr(A_PWR, 32'h00000000, rsp);
		for (n = 0; n < 40 && mclk_en !== 1'b1; n++) @(posedge aclk);
		chk("mclk_en back", 1, 32'(mclk_en));
		// parameter memory ends, target write-only, holes refused
		lfsr = lfsr_next(lfsr);
		v = lfsr;
		axi_wr(16'h1000, v, rsp);
		axi_wr(16'h1FFC, ~v, rsp);
		axi_rd(16'h1000, d, rsp);
		chk("param first", v, d);
		axi_rd(16'h1FFC, d, rsp);
		chk("param last", ~v, d);
		axi_wr(16'h20FC, v, rsp);
		chk("target wr bresp", 32'(RESP_OKAY), 32'(rsp));
		axi_rd(16'h20FC, d, rsp);
		chk("target rd rresp", 32'(RESP_SLVERR), 32'(rsp));
		chk("target rd data", 0, d);
		axi_rd(16'h2100, d, rsp);
		chk("current rd rresp", 32'(RESP_OKAY), 32'(rsp));
		axi_rd(16'h3000, d, rsp);
		chk("unmapped rresp", 32'(RESP_SLVERR), 32'(rsp));
		axi_wr(A_STATUS, v, rsp);
		chk("status wr bresp", 32'(RESP_SLVERR), 32'(rsp));
		// ramp location 1: unit linear step per tick, must settle on target
		axi_wr(A_RAMP_CFG, 32'h00000000, rsp);
		axi_wr(16'h2104, 32'h00000000, rsp);
		axi_wr(16'h2004, 32'h00000003, rsp);
		repeat (4000) @(posedge aclk);
		axi_rd(16'h2104, d, rsp);
		chk("ramp settled", 32'h00000003, d);
		// converter powered: output sample timing
		axi_wr(A_SPORT, 32'(FMT_LJ), rsp);
		axi_wr(A_PWR, 32'h00001000, rsp);
		n = tick_cnt;
		for (i = 0; i < 3000 && tick_cnt < n + 2; i++) @(posedge aclk);
		chk("tick period", 40_000_000 / 48_000, 32'(tick_gap));
		// mux off feeds lane three, then every select code with mux on
		for (k = -1; k < 4; k++) begin
			axi_wr(A_SRC_PORT, 32'((k < 0) ? 1 : k) << SRC_SEL_LSB, rsp);
			axi_wr(A_UCTL1, (k < 0) ? 32'h00000000 : 32'h00000008, rsp);
			for (i = 0; i < 4; i++) begin
				lfsr = lfsr_next(lfsr);
				exp_l[i] = lfsr[23:0];
				lfsr = lfsr_next(lfsr);
				exp_r[i] = lfsr[23:0];
			end
			send_lj();
			ln = (k < 0) ? 3 : k;
			chk("src_valid", 1, 32'(got_src));
			chk("src_left", 32'(exp_l[ln]), 32'(src_lq));
			chk("src_right", 32'(exp_r[ln]), 32'(src_rq));
			for (i = 0; i < 4; i++) begin
				chk("core_left", (i == k) ? 0 : 32'(exp_l[i]), 32'(core_lq[i]));
				chk("core_right", (i == k) ? 0 : 32'(exp_r[i]), 32'(core_rq[i]));
			end
		end
		finish_test();
	end
endmodule
